// *** bench/three_wire_serial_port_tb.sv ***
// self-checking bench for the three-wire serial port
// assumes tws_pkg and the peripheral model tws_periph
`timescale 1ns/1ns

module three_wire_serial_port_tb;
   localparam logic [15:0] BASE = 16'hFF80;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  wdata = 8'h00;
   logic [7:0]  rdata;
   logic        tx_ready, sck_o, sck_oe, so, si;
   logic        clr = 1'b0, watch = 1'b0, so_bad = 1'b0, sck_in = 1'b1;
   logic [7:0]  ptx = 8'h00, prx, v;
   logic [15:0] offs [5];
   int          frames, f0, n, error_cnt = 0, tests_run = 0, cyc = 0;

   tws_port #(.BASE(BASE)) uut (
      .CLK_I(clk), .RESET_N_I(rst_n), .CPU_ADDR_I(addr),
      .CPU_WR_I(wr), .CPU_RD_I(rd), .CPU_WDATA_I(wdata),
      .CPU_RDATA_O(rdata), .CPU_TX_READY_O(tx_ready),
      .SCK_I(sck_in), .SCK_O(sck_o), .SCK_OE_O(sck_oe),
      .SI_I(si), .SO_O(so), .SSEL_N_I(1'b1));

   tws_periph peer (
      .sck_i(sck_oe ? sck_o : sck_in), .sdo_i(so), .sdi_o(si), .clr_i(clr),
      .tx_byte_i(ptx), .rx_byte_o(prx), .frames_o(frames));

   // 25 MHz system clock
   always #20 clk = ~clk;

   // cut a hang short; the whole run needs well under this
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         $display("BAD timeout expected 0 seen %0d", cyc);
         error_cnt++;
         print_verdict();
      end
   end

   // output line must stay low through a receive-only word
   always @(negedge clk) if (watch && so !== 1'b0) so_bad = 1'b1;

   function automatic logic [7:0] rev(input logic [7:0] b);
      for (int i = 0; i < 8; i++) rev[i] = b[7 - i];
   endfunction : rev

   task automatic chk(input string name, input logic [7:0] e, g);
      tests_run++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", name, e, g);
         error_cnt++;
      end
   endtask : chk

   task automatic wr_reg(input logic [15:0] ofs, input logic [7:0] d);
      @(posedge clk);
      addr <= BASE + ofs;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // read data is registered, so it is taken a half cycle after the strobe
   task automatic rd_reg(input logic [15:0] ofs, output logic [7:0] d);
      @(posedge clk);
      addr <= BASE + ofs;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : rd_reg

   task automatic wait_idle();
      logic [7:0] m;
      int k;
      m = 8'h01;
      k = 0;
      while (m[0] !== 1'b0 && k < 3000) begin
         rd_reg(tws_pkg::MODE_OFS, m);
         k++;
      end
      if (k >= 3000) begin
         $display("BAD idle expected 0 seen 1");
         error_cnt++;
      end
   endtask : wait_idle

   // one full-duplex word; the peer answers with the inverse
   task automatic xfer(input logic [7:0] mode, input logic [7:0] d);
      logic [7:0] m;
      ptx <= ~d;
      wr_reg(tws_pkg::MODE_OFS, mode);
      wr_reg(tws_pkg::TXBUF_OFS, d);
      @(posedge clk);
      rd_reg(tws_pkg::MODE_OFS, m);
      chk("busy", 8'h01, {7'h00, m[0]});
      wait_idle();
      chk("peer rx", mode[4] ? rev(d) : d, prx);
      rd_reg(tws_pkg::SHIFT_OFS, m);
      chk("shift", mode[4] ? rev(~d) : ~d, m);
      rd_reg(tws_pkg::TXBUF_OFS, m);
      chk("txbuf", d, m);
   endtask : xfer

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict

   initial begin
      offs = '{tws_pkg::MODE_OFS, tws_pkg::CLKSEL_OFS, tws_pkg::TXBUF_OFS,
               tws_pkg::SHIFT_OFS, 16'h0002};
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      // reset values, unmapped place reads zero
      foreach (offs[i]) begin
         rd_reg(offs[i], v);
         chk("reset value", 8'h00, v);
      end
      chk("stopped clock drive", 8'h00, {7'h00, sck_oe});
      chk("stopped so", 8'h00, {7'h00, so});
      // clock select: low phase lasts 2**cks system cycles
      for (int c = 0; c < 7; c++) begin
         wr_reg(tws_pkg::CLKSEL_OFS, 8'(c));
         wr_reg(tws_pkg::MODE_OFS, 8'hC0);
         wr_reg(tws_pkg::TXBUF_OFS, 8'h5A);
         n = 0;
         while (sck_o === 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
         end
         n = 0;
         while (sck_o === 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
         end
         chk("half period", 8'(1 << c), 8'(n));
         wait_idle();
      end
      wr_reg(tws_pkg::CLKSEL_OFS, 8'h07);
      @(negedge clk);
      chk("slave clock drive", 8'h00, {7'h00, sck_oe});
      // slave mode: the bench clocks the link, 8 system cycles a phase,
      // slow enough for the three-flop path on the clock pin
      wr_reg(tws_pkg::MODE_OFS, 8'hC0);
      ptx <= 8'h96;
      wr_reg(tws_pkg::TXBUF_OFS, 8'hC3);
      repeat (8) begin
         repeat (8) @(posedge clk);
         sck_in <= 1'b0;
         repeat (8) @(posedge clk);
         sck_in <= 1'b1;
      end
      repeat (8) @(posedge clk);
      rd_reg(tws_pkg::MODE_OFS, v);
      chk("slave idle", 8'hC0, v);
      chk("slave peer rx", 8'hC3, prx);
      rd_reg(tws_pkg::SHIFT_OFS, v);
      chk("slave shift", 8'h96, v);
      wr_reg(tws_pkg::CLKSEL_OFS, 8'h02);
      // full duplex, both bit orders
      xfer(8'hC0, 8'hA5);
      xfer(8'hD0, 8'h3C);
      // receive only: read starts it, output held low
      wr_reg(tws_pkg::MODE_OFS, 8'h80);
      ptx <= 8'h6B;
      f0 = frames;
      watch = 1'b1;
      rd_reg(tws_pkg::SHIFT_OFS, v);
      wait_idle();
      watch = 1'b0;
      chk("rx frames", 8'(f0 + 1), 8'(frames));
      chk("so low", 8'h00, {7'h00, so_bad});
      rd_reg(tws_pkg::SHIFT_OFS, v);
      chk("rx only", 8'h6B, v);
      wait_idle();
      // buffer writes that must not start a word
      f0 = frames;
      wr_reg(tws_pkg::MODE_OFS, 8'h40);
      wr_reg(tws_pkg::TXBUF_OFS, 8'h11);
      wr_reg(tws_pkg::MODE_OFS, 8'h80);
      wr_reg(tws_pkg::TXBUF_OFS, 8'h22);
      repeat (40) @(posedge clk);
      chk("no start", 8'(f0), 8'(frames));
      rd_reg(tws_pkg::TXBUF_OFS, v);
      chk("txbuf back", 8'h22, v);
      // abort in mid-word by clearing enable
      wr_reg(tws_pkg::MODE_OFS, 8'hC0);
      wr_reg(tws_pkg::TXBUF_OFS, 8'hFF);
      repeat (12) @(posedge clk);
      wr_reg(tws_pkg::MODE_OFS, 8'h00);
      rd_reg(tws_pkg::MODE_OFS, v);
      chk("abort mode", 8'h00, v);
      rd_reg(tws_pkg::SHIFT_OFS, v);
      chk("abort shift", 8'h00, v);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      // queue: ten writes back to back, the tenth is refused
      wr_reg(tws_pkg::MODE_OFS, 8'hC0);
      f0 = frames;
      for (int i = 0; i < 10; i++) wr_reg(tws_pkg::TXBUF_OFS, 8'(16 + i));
      @(negedge clk);
      chk("queue full", 8'h00, {7'h00, tx_ready});
      n = 0;
      while (frames < f0 + 9 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      repeat (200) @(posedge clk);
      chk("queued words", 8'(f0 + 9), 8'(frames));
      chk("last word", 8'h18, prx);
      chk("queue room", 8'h01, {7'h00, tx_ready});
      print_verdict();
   end
endmodule : three_wire_serial_port_tb

// *** bench/tws_periph.sv ***
// behavioural peripheral at the far side of the three-wire link
// assumes the port's clock idles high, shifts on fall, samples on rise
`timescale 1ns/1ns

module tws_periph (
   // link pins
   input  wire logic       sck_i,
   input  wire logic       sdo_i,
   output logic            sdi_o,
   // bench control and view
   input  wire logic       clr_i,
   input  wire logic [7:0] tx_byte_i,
   output logic [7:0]      rx_byte_o,
   output int              frames_o
);
   int cnt;

   initial begin
      sdi_o = 1'b0;
      rx_byte_o = 8'h00;
      frames_o = 0;
      cnt = 0;
   end

   // bench realigns the bit count after reset or an aborted word
   always @(posedge clr_i) cnt = 0;

   // next data bit goes out on each falling clock, msb of word first
   always @(negedge sck_i) sdi_o <= tx_byte_i[7 - cnt];

   // capture on rise; after the eighth bit the line is let go, and
   // flipping it then stops a stale level passing for valid data
   always @(posedge sck_i) begin
      rx_byte_o <= {rx_byte_o[6:0], sdo_i};
      if (cnt == 7) begin
         cnt = 0;
         frames_o++;
         sdi_o <= #100 ~sdi_o;
      end else begin
         cnt = cnt + 1;
      end
   end
endmodule : tws_periph

// *** core/tws_port.sv ***
// three-wire serial port: registers, transmit queue and shift engine
// assumes CLK_I at 25 MHz; SCK_I, SI_I and SSEL_N_I come from pins
//
// Summary of operation
// - disabled port stays idle to save power
// - eight-bit words over clock, in, out
// - transmit and receive shift in one transfer
// - software picks msb or lsb first
// - buffer write starts when enable and mode
// - buffer word loaded, shifted onto output
// - buffer byte access, resets to zero
// - one shift register, byte read, resets zero
// - shift read starts receive when mode clear
// - input line sampled into shift register
// - slave select only counts in slave mode
// - clearing enable resets flag and shifter
// - busy flag reads one during transfer
// - output held low when mode clear
// - clock select divides 2..128, 7 slave
`timescale 1ns/1ns

// small synchronous fifo, storage in flip-flops
module tws_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         flush_i,
   // fill side
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   // drain side
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_IX = AW'(DEPTH - 1);

   logic [W-1:0]  mem_r [DEPTH];
   logic [AW-1:0] wr_ix_r;
   logic [AW-1:0] rd_ix_r;
   logic [AW:0]   cnt_r;
   logic          push;
   logic          pop;

   // full and empty come straight from the fill count
   assign in_ready_o  = cnt_r != FULL_CNT;
   assign out_valid_o = cnt_r != '0;
   assign out_data_o  = mem_r[rd_ix_r];
   assign push = in_valid_i && in_ready_o;
   assign pop  = out_valid_o && out_ready_i;

   // storage is written only, never reset
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wr_ix_r] <= in_data_i;
      end
   end

   // pointers wrap at depth, which need not be a power of two
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ix_r <= '0;
         rd_ix_r <= '0;
         cnt_r   <= '0;
      end else if (flush_i) begin
         wr_ix_r <= '0;
         rd_ix_r <= '0;
         cnt_r   <= '0;
      end else begin
         if (push) begin
            wr_ix_r <= (wr_ix_r == LAST_IX) ? '0 : wr_ix_r + 1'b1;
         end
         if (pop) begin
            rd_ix_r <= (rd_ix_r == LAST_IX) ? '0 : rd_ix_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule : tws_fifo

module tws_port #(
   parameter logic [15:0] BASE       = 16'hFF80,
   parameter bit          HAS_SSEL   = 1'b0,
   parameter int          FIFO_DEPTH = 8
) (
   // clock and reset
   input  wire logic        CLK_I,
   input  wire logic        RESET_N_I,
   // cpu register port
   input  wire logic [15:0] CPU_ADDR_I,
   input  wire logic        CPU_WR_I,
   input  wire logic        CPU_RD_I,
   input  wire logic [7:0]  CPU_WDATA_I,
   output logic [7:0]       CPU_RDATA_O,
   output logic             CPU_TX_READY_O,
   // serial link
   input  wire logic        SCK_I,
   output logic             SCK_O,
   output logic             SCK_OE_O,
   input  wire logic        SI_I,
   output logic             SO_O,
   input  wire logic        SSEL_N_I
);
   typedef enum logic {ST_IDLE, ST_RUN} tws_state_t;

   tws_pkg::tws_req_t  req;
   tws_pkg::tws_mode_t mode_r;
   tws_state_t         state_r;
   logic [2:0]  cks_r;
   logic [7:0]  txbuf_r;
   logic [7:0]  sr_r;
   logic [7:0]  sr_nxt;
   logic [7:0]  rdata_r;
   logic [2:0]  bit_cnt_r;
   logic [6:0]  div_r;
   logic [6:0]  div_lim;
   logic        sck_r;
   logic        so_r;
   logic        busy;
   logic        master;
   logic        tick;
   logic        rise_ev;
   logic        fall_ev;
   logic        ss_ok;
   logic        hit_mode;
   logic        hit_clk;
   logic        hit_tx;
   logic        hit_sh;
   logic        q_valid;
   logic [7:0]  q_data;
   logic        pop;
   logic        start_rx;
   logic        sck_s1_r;
   logic        sck_s2_r;
   logic        sck_s3_r;
   logic        si_s1_r;
   logic        si_s2_r;
   logic        ssn_s1_r;
   logic        ssn_s2_r;

   // pack the cpu strobes and decode the four offsets
   assign req = '{wr: CPU_WR_I, rd: CPU_RD_I,
                  addr: CPU_ADDR_I - BASE, data: CPU_WDATA_I};
   assign hit_mode = req.addr == tws_pkg::MODE_OFS;
   assign hit_clk  = req.addr == tws_pkg::CLKSEL_OFS;
   assign hit_tx   = req.addr == tws_pkg::TXBUF_OFS;
   assign hit_sh   = req.addr == tws_pkg::SHIFT_OFS;
   assign busy     = state_r == ST_RUN;
   assign master   = cks_r != tws_pkg::CKS_SLAVE;

   // pins are foreign to CLK_I, so two flops before any use
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         sck_s1_r <= 1'b1;
         sck_s2_r <= 1'b1;
         sck_s3_r <= 1'b1;
         si_s1_r  <= 1'b0;
         si_s2_r  <= 1'b0;
         ssn_s1_r <= 1'b1;
         ssn_s2_r <= 1'b1;
      end else begin
         sck_s1_r <= SCK_I;
         sck_s2_r <= sck_s1_r;
         sck_s3_r <= sck_s2_r;
         si_s1_r  <= SI_I;
         si_s2_r  <= si_s1_r;
         ssn_s1_r <= SSEL_N_I;
         ssn_s2_r <= ssn_s1_r;
      end
   end

   // mode and clock select registers
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         mode_r <= tws_pkg::tws_mode_t'(tws_pkg::MODE_RST[7:4]);
         cks_r  <= tws_pkg::CKS_RST;
      end else if (req.wr && hit_mode) begin
         mode_r.en   <= req.data[tws_pkg::EN_BIT];
         mode_r.trmd <= req.data[tws_pkg::TRMD_BIT];
         mode_r.sse  <= HAS_SSEL && req.data[tws_pkg::SSE_BIT];
         mode_r.dir  <= req.data[tws_pkg::DIR_BIT];
      end else if (req.wr && hit_clk) begin
         cks_r <= req.data[2:0];
      end
   end

   // transmit buffer keeps the last byte written for read back
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         txbuf_r <= tws_pkg::TXBUF_RST;
      end else if (req.wr && hit_tx) begin
         txbuf_r <= req.data;
      end
   end

   // queue absorbs back to back writes; ready tells the cpu to wait
   tws_fifo #(
      .W     (8),
      .DEPTH (FIFO_DEPTH)
   ) u_txq (
      .clk_i       (CLK_I),
      .rst_n_i     (RESET_N_I),
      .flush_i     (!mode_r.en),
      .in_valid_i  (req.wr && hit_tx && mode_r.en && mode_r.trmd),
      .in_ready_o  (CPU_TX_READY_O),
      .in_data_i   (req.data),
      .out_valid_o (q_valid),
      .out_ready_i (pop),
      .out_data_o  (q_data)
   );

   // a word leaves the queue only when the engine is free
   assign pop = q_valid && !busy && mode_r.en && mode_r.trmd;
   assign start_rx = req.rd && hit_sh && mode_r.en && !mode_r.trmd
                     && !busy;

   // slave select gates the clock only in slave mode
   assign ss_ok = !(HAS_SSEL && mode_r.sse && !master && ssn_s2_r);

   // master half period is 2**cks cycles, giving fx/2..fx/128
   assign div_lim = (7'h01 << cks_r) - 7'h01;
   assign tick    = busy && master && div_r == div_lim;
   // no edge counts once enable is gone, so an abort never half-shifts
   assign rise_ev = busy && mode_r.en && (master ? tick && !sck_r
                    : sck_s2_r && !sck_s3_r && ss_ok);
   assign fall_ev = busy && mode_r.en && (master ? tick && sck_r
                    : !sck_s2_r && sck_s3_r && ss_ok);

   // master clock divider; the line rests high between words
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         div_r <= 7'h00;
         sck_r <= 1'b1;
      end else if (!busy || !mode_r.en) begin
         div_r <= 7'h00;
         sck_r <= 1'b1;
      end else if (tick) begin
         div_r <= 7'h00;
         sck_r <= !sck_r;
      end else if (master) begin
         div_r <= div_r + 7'h01;
      end
   end

   // next shift value: input bit enters at the far end
   always_comb begin
      if (mode_r.dir) begin
         sr_nxt = {si_s2_r, sr_r[7:1]};
      end else begin
         sr_nxt = {sr_r[6:0], si_s2_r};
      end
   end

   // transfer engine; disable clears it on the next edge
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         state_r   <= ST_IDLE;
         sr_r      <= tws_pkg::SHIFT_RST;
         bit_cnt_r <= 3'h0;
      end else if (!mode_r.en) begin
         state_r   <= ST_IDLE;
         sr_r      <= tws_pkg::SHIFT_RST;
         bit_cnt_r <= 3'h0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               bit_cnt_r <= 3'h0;
               if (pop) begin
                  sr_r    <= q_data;
                  state_r <= ST_RUN;
               end else if (start_rx) begin
                  state_r <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (rise_ev) begin
                  sr_r      <= sr_nxt;
                  bit_cnt_r <= bit_cnt_r + 3'h1;
                  if (bit_cnt_r == tws_pkg::LAST_BIT) begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // output bit changes on the falling edge, held low in receive mode
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         so_r <= 1'b0;
      end else if (!mode_r.trmd || !mode_r.en) begin
         so_r <= 1'b0;
      end else if (pop) begin
         so_r <= mode_r.dir ? q_data[0] : q_data[7];
      end else if (fall_ev) begin
         so_r <= mode_r.dir ? sr_r[0] : sr_r[7];
      end
   end

   // read data is registered, valid the cycle after the strobe
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rdata_r <= 8'h00;
      end else if (req.rd) begin
         if (hit_mode) begin
            rdata_r <= {mode_r, 3'h0, busy};
         end else if (hit_clk) begin
            rdata_r <= {5'h00, cks_r};
         end else if (hit_tx) begin
            rdata_r <= txbuf_r;
         end else if (hit_sh) begin
            rdata_r <= sr_r;
         end else begin
            rdata_r <= 8'h00;
         end
      end
   end

   assign CPU_RDATA_O = rdata_r;
   assign SCK_O       = sck_r;
   assign SCK_OE_O    = master && mode_r.en;
   assign SO_O        = so_r;

   // checks
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESET_N_I);

   sequence s_last_rise;
      busy && rise_ev && bit_cnt_r == tws_pkg::LAST_BIT;
   endsequence

   property p_off_idle;
      !mode_r.en |=> !busy && sr_r == 8'h00;
   endproperty
   a_off_idle: assert property (p_off_idle)
      else $error("port busy while disabled");

   property p_so_low;
      !mode_r.trmd |=> !SO_O;
   endproperty
   a_so_low: assert property (p_so_low)
      else $error("output not low in receive mode");

   property p_tx_start;
      q_valid && !busy && mode_r.en && mode_r.trmd |=> busy;
   endproperty
   a_tx_start: assert property (p_tx_start)
      else $error("queued word did not start");

   property p_rx_start;
      start_rx |=> busy ##0 bit_cnt_r == 3'h0;
   endproperty
   a_rx_start: assert property (p_rx_start)
      else $error("shift read did not start receive");

   property p_done;
      s_last_rise |=> !busy ##0 $past(sr_nxt) == sr_r;
   endproperty
   a_done: assert property (p_done)
      else $error("flag not cleared after eighth bit");

   property p_count;
      busy && rise_ev && bit_cnt_r != tws_pkg::LAST_BIT
         |=> busy && bit_cnt_r == $past(bit_cnt_r) + 3'h1;
   endproperty
   a_count: assert property (p_count)
      else $error("bit count did not advance");

   property p_msb_in;
      busy && rise_ev && !mode_r.dir |=> sr_r[0] == $past(si_s2_r);
   endproperty
   a_msb_in: assert property (p_msb_in)
      else $error("input bit not at lsb end");

   property p_lsb_in;
      busy && rise_ev && mode_r.dir |=> sr_r[7] == $past(si_s2_r);
   endproperty
   a_lsb_in: assert property (p_lsb_in)
      else $error("input bit not at msb end");

   property p_so_bit;
      busy && fall_ev && mode_r.en && mode_r.trmd && !mode_r.dir
         |=> SO_O == $past(sr_r[7]);
   endproperty
   a_so_bit: assert property (p_so_bit)
      else $error("output bit not from shift register");

   property p_ss_gate;
      !master && HAS_SSEL && mode_r.sse && ssn_s2_r |-> !rise_ev;
   endproperty
   a_ss_gate: assert property (p_ss_gate)
      else $error("edge taken while deselected");

   property p_fast_clk;
      busy && master && cks_r == 3'h0
         && !(rise_ev && bit_cnt_r == tws_pkg::LAST_BIT)
         |=> SCK_O != $past(SCK_O) || !busy;
   endproperty
   a_fast_clk: assert property (p_fast_clk)
      else $error("fastest clock did not toggle each cycle");
endmodule : tws_port

// *** include/tws_pkg.sv ***
// constants and carrier types of the three-wire serial port
// assumes a byte-wide cpu register port with one-cycle strobes
package tws_pkg;
   // register offsets from the port base address
   localparam logic [15:0] MODE_OFS   = 16'h0000;
   localparam logic [15:0] CLKSEL_OFS = 16'h0001;
   localparam logic [15:0] TXBUF_OFS  = 16'h0004;
   localparam logic [15:0] SHIFT_OFS  = 16'h0005;
   // mode register field positions
   localparam int EN_BIT   = 7;
   localparam int TRMD_BIT = 6;
   localparam int SSE_BIT  = 5;
   localparam int DIR_BIT  = 4;
   localparam int BUSY_BIT = 0;
   // reset values
   localparam logic [7:0] MODE_RST   = 8'h00;
   localparam logic [2:0] CKS_RST    = 3'h0;
   localparam logic [7:0] TXBUF_RST  = 8'h00;
   localparam logic [7:0] SHIFT_RST  = 8'h00;
   // clock select code for external clock
   localparam logic [2:0] CKS_SLAVE  = 3'h7;
   // index of the last bit of a word
   localparam logic [2:0] LAST_BIT   = 3'h7;
   // cpu register request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  data;
   } tws_req_t;
   // mode register contents
   typedef struct packed {
      logic en;
      logic trmd;
      logic sse;
      logic dir;
   } tws_mode_t;
endpackage : tws_pkg
